//--- rtl/ascs_sequencer.sv
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ascs_regs.svh"
// Overview of operation
// - with stop bit set, first conversion interrupt clears auto-sample-start in hardware.
// - with stop bit clear, sequences keep running and overwrite the result.
// - auto-sample-start set: sampling restarts right after a conversion ends.
// - auto-sample-start clear: no sampling until sample-enable is set.
// - sample-enable reads one while acquiring, zero while holding.
// - with auto-sample-start clear, writing one to sample-enable starts sampling.
// - manual trigger source: writing zero to sample-enable ends sampling, starts conversion.
// - nonzero trigger source: hardware clears sample-enable and starts conversion.
// - done reads one after a conversion completes, zero before.
// - software clears done only by writing zero; writing one never sets it.
// - clearing done does not disturb sampling or conversion in progress.
// - hardware clears done whenever a new conversion starts.
// - bit 3 reads zero and ignores writes.
module ascs_sequencer (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ascs_pkg::ascs_result_t convData,
    output logic sampleHold,
    output logic convStart,
    output logic irq
);
    import ascs_pkg::*;

    logic rstMeta_q, rstN;
    // reset released through two flops, asserted at once
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    ascs_state_t state_q, state_d;
    logic stopOnIrq_q, stopOnIrq_d, autoStart_q, autoStart_d;
    logic done_q, done_d;
    ascs_trig_t trig_q, trig_d;
    ascs_result_t result_q, result_d;
    logic [1:0] stat_q, stat_d, mask_q, mask_d;
    logic [4:0] timLoad;
    logic timLoadEn, timDone, convEnd;
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
    logic [3:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic bValid_d, arReady_d, rValid_d, awReady_d, wReady_d;
    logic [31:0] rData_d, ctrlView;
    logic wrFire, wrCtrl;
    logic [4:0] evt;

    // one timer serves both the auto sample window and the conversion
    ascs_conv_timer ascs_conv_timer_inst (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .clkEn(clkEn),
        .load(timLoadEn),
        .loadVal(timLoad),
        .done(timDone)
    );

    assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrCtrl = wrFire && (awAddr_q == `ASCS_CTRL_OFS) && wStrb_q[0];
    assign convEnd = (state_q == ASCS_CONVERTING) && timDone;

    // control bits read back; bit 3 is hardwired zero
    always_comb begin
        ctrlView = 32'h0000_0000;
        ctrlView[`ASCS_DONE_BIT] = done_q;
        ctrlView[`ASCS_SAMPLE_ENABLE_BIT] = (state_q == ASCS_SAMPLING);
        ctrlView[`ASCS_AUTO_SAMPLE_START_BIT] = autoStart_q;
        ctrlView[`ASCS_CLR_BIT] = stopOnIrq_q;
        ctrlView[`ASCS_TRIG_HI:`ASCS_TRIG_LO] = trig_q;
    end

    // sequence state: software writes steer it, hardware events move it
    always_comb begin
        state_d = state_q;
        stopOnIrq_d = stopOnIrq_q;
        autoStart_d = autoStart_q;
        trig_d = trig_q;
        done_d = done_q;
        result_d = result_q;
        timLoadEn = 1'b0;
        timLoad = 5'h00;
        if (wrCtrl) begin
            stopOnIrq_d = wData_q[`ASCS_CLR_BIT];
            autoStart_d = wData_q[`ASCS_AUTO_SAMPLE_START_BIT]; // bit 3 dropped
            trig_d = wData_q[`ASCS_TRIG_HI:`ASCS_TRIG_LO];
            if (!wData_q[`ASCS_DONE_BIT]) begin
                done_d = 1'b0;
            end
        end
        case (state_q)
            ASCS_IDLE: begin
                if (wrCtrl && wData_q[`ASCS_SAMPLE_ENABLE_BIT] && !autoStart_q) begin
                    state_d = ASCS_SAMPLING;
                end else if (autoStart_q) begin
                    state_d = ASCS_SAMPLING;
                end
                if (state_d == ASCS_SAMPLING && trig_d != 3'h0) begin
                    timLoadEn = 1'b1;
                    timLoad = 5'(`ASCS_AUTO_SAMPLE_CYC);
                end
            end
            ASCS_SAMPLING: begin
                if ((trig_q == 3'h0 && wrCtrl && !wData_q[`ASCS_SAMPLE_ENABLE_BIT])
                        || (trig_q != 3'h0 && timDone)) begin
                    state_d = ASCS_CONVERTING;
                    done_d = 1'b0;
                    timLoadEn = 1'b1;
                    timLoad = 5'(`ASCS_CONV_CYC);
                end else if (wrCtrl && wData_q[`ASCS_TRIG_HI:`ASCS_TRIG_LO] != 3'h0
                        && wData_q[`ASCS_TRIG_HI:`ASCS_TRIG_LO] != trig_q) begin
                    // covers a switch from manual to timed, which would else never end
                    timLoadEn = 1'b1; // trigger source changed mid-sample
                    timLoad = 5'(`ASCS_AUTO_SAMPLE_CYC);
                end
            end
            ASCS_CONVERTING: begin
                if (convEnd) begin
                    done_d = 1'b1;
                    result_d = convData; // overwrite
                    state_d = ASCS_IDLE;
                    if (stopOnIrq_q) begin
                        autoStart_d = 1'b0;
                    end
                    // auto restart of sampling happens from idle next cycle
                end
            end
            default: begin
                state_d = ASCS_IDLE;
            end
        endcase
    end

    // events: bit0 conversion complete, bit1 sequence stopped
    assign evt = {3'b000, convEnd && stopOnIrq_q, convEnd};

    // sticky status, write-one-to-clear; a new event beats the clear
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (wrFire && awAddr_q == `ASCS_IRQ_STAT_OFS && wStrb_q[0]) begin
            stat_d = stat_q & ~wData_q[1:0];
        end
        if (wrFire && awAddr_q == `ASCS_IRQ_MASK_OFS && wStrb_q[0]) begin
            mask_d = wData_q[1:0];
        end
        stat_d = stat_d | evt[1:0];
    end

    // AXI4-Lite slave: address and data latched independently
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = s_axi_bvalid;
        awReady_d = 1'b0;
        wReady_d = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_d = 1'b1;
            awAddr_d = {s_axi_awaddr[3:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (wrFire) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bValid_d = 1'b0;
        end
        awReady_d = !awHeld_d && !bValid_d && !s_axi_awready;
        wReady_d = !wHeld_d && !bValid_d && !s_axi_wready;
        rValid_d = s_axi_rvalid;
        rData_d = s_axi_rdata;
        arReady_d = 1'b0;
        if (s_axi_rvalid && s_axi_rready) begin
            rValid_d = 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_d = 1'b1;
            case ({s_axi_araddr[3:2], 2'b00})
                `ASCS_CTRL_OFS: rData_d = ctrlView;
                `ASCS_IRQ_STAT_OFS: rData_d = {30'h0, stat_q};
                `ASCS_IRQ_MASK_OFS: rData_d = {30'h0, mask_q};
                `ASCS_RESULT_OFS: rData_d = {22'h0, result_q};
                default: rData_d = 32'h0000_0000;
            endcase
        end
        if (!rValid_d && !s_axi_arready && !(s_axi_arvalid && s_axi_arready)) begin
            arReady_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_q <= ASCS_IDLE;
            stopOnIrq_q <= 1'b0;
            autoStart_q <= 1'b0;
            trig_q <= 3'h0;
            done_q <= 1'b0;
            result_q <= 10'h000;
            stat_q <= 2'h0;
            mask_q <= `ASCS_MASK_RST;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_bresp <= 2'b00;
            s_axi_rresp <= 2'b00;
            sampleHold <= 1'b0;
            convStart <= 1'b0;
            irq <= 1'b0;
        end else if (clkEn) begin
            state_q <= state_d;
            stopOnIrq_q <= stopOnIrq_d;
            autoStart_q <= autoStart_d;
            trig_q <= trig_d;
            done_q <= done_d;
            result_q <= result_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            s_axi_awready <= awReady_d;
            s_axi_wready <= wReady_d;
            s_axi_bvalid <= bValid_d;
            s_axi_arready <= arReady_d;
            s_axi_rvalid <= rValid_d;
            s_axi_rdata <= rData_d;
            s_axi_bresp <= 2'b00; // always okay, kept in a flop like every output
            s_axi_rresp <= 2'b00;
            sampleHold <= (state_d == ASCS_SAMPLING);
            convStart <= (state_q == ASCS_SAMPLING) && (state_d == ASCS_CONVERTING);
            irq <= |(stat_d & mask_d);
        end
    end

    a_stop_clears_auto: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && convEnd && stopOnIrq_q |=> !autoStart_q)
        else $error("auto start survived stop on interrupt");
    a_done_on_end: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && convEnd |=> done_q)
        else $error("done not set at conversion end");
    a_done_cleared_start: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && convStart |-> !done_q)
        else $error("done still set at conversion start");
    a_auto_restart: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && state_q == ASCS_IDLE && autoStart_q |=> state_q == ASCS_SAMPLING || !clkEn)
        else $error("auto sampling did not restart");
    a_no_sample_idle: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && state_q == ASCS_IDLE && !autoStart_q && !wrCtrl |=> state_q != ASCS_SAMPLING)
        else $error("sampling began without request");
    a_sample_enable_reflects: assert property (@(posedge clk_sys) disable iff (!rstN)
        sampleHold == (state_q == ASCS_SAMPLING))
        else $error("sample output disagrees with state");
    a_manual_conv: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && state_q == ASCS_SAMPLING && trig_q == 3'h0 && wrCtrl
            && !wData_q[`ASCS_SAMPLE_ENABLE_BIT] |=> state_q == ASCS_CONVERTING)
        else $error("manual end of sample failed");
    a_done_one_no_set: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && !done_q && !convEnd |=> !done_q)
        else $error("done set without a conversion");
    a_clear_no_disturb: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && wrCtrl && state_q == ASCS_CONVERTING && !convEnd |=> state_q == ASCS_CONVERTING)
        else $error("clear disturbed conversion");
    a_irq_event: assert property (@(posedge clk_sys) disable iff (!rstN)
        clkEn && convEnd |=> stat_q[0])
        else $error("interrupt event missing");
endmodule // ascs_sequencer
`default_nettype wire

//--- inc/ascs_regs.svh
`ifndef ASCS_REGS_SVH
`define ASCS_REGS_SVH
// register byte offsets
`define ASCS_CTRL_OFS 4'h0
`define ASCS_IRQ_STAT_OFS 4'h4
`define ASCS_IRQ_MASK_OFS 4'h8
`define ASCS_RESULT_OFS 4'hC
// control field positions
`define ASCS_DONE_BIT 0
`define ASCS_SAMPLE_ENABLE_BIT 1
`define ASCS_AUTO_SAMPLE_START_BIT 2
`define ASCS_CLR_BIT 4
`define ASCS_TRIG_LO 5
`define ASCS_TRIG_HI 7
// reset values
`define ASCS_CTRL_RST 32'h0000_0000
`define ASCS_MASK_RST 2'h0
// timing: fixed auto-trigger sample time and conversion time, in cycles
`define ASCS_AUTO_SAMPLE_NS 400
`define ASCS_CLK_NS 50
`define ASCS_AUTO_SAMPLE_CYC (`ASCS_AUTO_SAMPLE_NS / `ASCS_CLK_NS)
`define ASCS_CONV_CYC 12
`endif

//--- inc/ascs_pkg.sv
package ascs_pkg;
    typedef enum logic [1:0] {
        ASCS_IDLE = 2'b00,
        ASCS_SAMPLING = 2'b01,
        ASCS_CONVERTING = 2'b10
    } ascs_state_t;
    typedef logic [2:0] ascs_trig_t;
    typedef logic [9:0] ascs_result_t;
endpackage

//--- rtl/ascs_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascs_regs.svh"
// counts a run of cycles; pulses done when the load count has expired
module ascs_conv_timer (
    input wire logic clk_sys,
    input wire logic rstN,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [4:0] loadVal,
    output logic done
);
    logic [4:0] cnt_q, cnt_d;
    logic done_d;
    // a new load restarts the run, so a stale count cannot leak over
    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (load) begin
            cnt_d = loadVal;
        end else if (cnt_q != 5'h00) begin
            cnt_d = cnt_q - 5'h01;
            done_d = (cnt_q == 5'h01);
        end
    end
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= 5'h00;
            done <= 1'b0;
        end else if (clkEn) begin
            cnt_q <= cnt_d;
            done <= done_d;
        end
    end
endmodule // ascs_conv_timer
`default_nettype wire

//--- dv/ascs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter core stand-in: a fresh word per conversion, noise on the line otherwise
module ascs_conv_model (
    input wire logic clk_sys,
    input wire logic convStart,
    output ascs_pkg::ascs_result_t convData,
    output ascs_pkg::ascs_result_t lastWord
);
    import ascs_pkg::*;
    int holdCnt = 0;
    ascs_result_t idleNoise = 10'h155;
    ascs_result_t word = 10'h2A5;
    // new word each conversion so that an overwritten result is visible
    always @(posedge clk_sys) begin
        idleNoise <= ~idleNoise;
        if (convStart === 1'b1) begin
            word <= {word[8:0], word[9] ^ word[6]};
            holdCnt <= 16;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
    end
    // held only over the conversion window; a late sample sees toggling noise
    assign convData = (holdCnt > 0) ? word : idleNoise;
    assign lastWord = word;
endmodule // ascs_conv_model
`default_nettype wire

//--- dv/adc_sample_convert_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascs_regs.svh"
module adc_sample_convert_sequencer_tb;
    import ascs_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd;
    logic awready, wready, bvalid, arready, rvalid, sampleHold, convStart, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    ascs_result_t convData, lastWord;
    int nErrors = 0, samplesChecked = 0, cycles = 0, nConv = 0, seed = 95, c0;
    logic [31:0] trig;
    always #25 clk_sys = ~clk_sys;
    ascs_sequencer ascs_sequencer_inst (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .convData(convData), .sampleHold(sampleHold), .convStart(convStart), .irq(irq));
    ascs_conv_model ascs_conv_model_inst (.clk_sys(clk_sys), .convStart(convStart),
        .convData(convData), .lastWord(lastWord));
    // conversions counted off the start pulse
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (convStart === 1'b1) nConv <= nConv + 1;
        if (cycles == 20000) begin
            nErrors = nErrors + 1;
            testDone();
        end
    end
    task automatic testDone();
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // handshakes judged at the rising edge; only the global timeout ends a wait
    task automatic axWrite(input logic [3:0] a, input logic [31:0] d);
        logic fin;
        fin = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!fin) begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                fin = 1'b1;
                chk("bresp", 32'h0, {30'h0, bresp});
            end
        end
        bready <= 1'b0;
        // one edge passes so the next call never re-raises bready in this step
        @(posedge clk_sys);
    endtask
    task automatic axRead(input logic [3:0] a, output logic [31:0] d);
        logic fin;
        fin = 1'b0;
        d = 32'h0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!fin) begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                fin = 1'b1;
                d = rdata;
                chk("rresp", 32'h0, {30'h0, rresp});
            end
        end
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    // poll the done flag until it rises; a hang is caught by the cycle ceiling
    task automatic waitDone();
        rd = 32'h0;
        while (rd[`ASCS_DONE_BIT] !== 1'b1) begin
            axRead(`ASCS_CTRL_OFS, rd);
        end
    endtask
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    initial begin
        waitCyc(2);
        nrst <= 1'b1;
        waitCyc(3);
        // reset values of control, status and mask
        for (int i = 0; i < 3; i++) begin
            axRead(4'(i * 4), rd);
            chk("reset value", 32'h0000_0000, rd);
        end
        $display("test reset done");
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0002);
        waitCyc(3);
        chk("sampleHold manual", 32'h1, {31'h0, sampleHold});
        axRead(`ASCS_CTRL_OFS, rd);
        chk("ctrl sampling", 32'h0000_0002, rd);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0000);
        waitDone();
        chk("ctrl done", 32'h0000_0001, rd);
        axRead(`ASCS_RESULT_OFS, rd);
        chk("result", {22'h0, lastWord}, rd);
        axRead(`ASCS_IRQ_STAT_OFS, rd);
        chk("status complete", 32'h1, rd & 32'h1);
        $display("test manual done");
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0009);
        axRead(`ASCS_CTRL_OFS, rd);
        chk("bit3 and done", 32'h0000_0001, rd);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0000);
        axRead(`ASCS_CTRL_OFS, rd);
        chk("done cleared", 32'h0, rd);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0001);
        axRead(`ASCS_CTRL_OFS, rd);
        chk("done not set", 32'h0, rd);
        $display("test done flag done");
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0002);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0000);
        waitDone();
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0003);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0001);
        axRead(`ASCS_CTRL_OFS, rd);
        chk("done at new conversion", 32'h0, rd);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0000);
        waitDone();
        chk("conversion survives clear", 32'h1, rd);
        $display("test done clear done");
        // freeze a conversion part way through; it must resume, not restart or finish
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0002);
        axWrite(`ASCS_CTRL_OFS, 32'h0000_0000);
        clkEn <= 1'b0;
        waitCyc(30);
        clkEn <= 1'b1;
        waitCyc(1);
        axRead(`ASCS_CTRL_OFS, rd);
        chk("frozen conversion", 32'h0, rd);
        waitDone();
        chk("done after freeze", 32'h1, rd);
        $display("test freeze done");
        trig = ({$random(seed)} % 7) + 1;
        c0 = nConv;
        axWrite(`ASCS_CTRL_OFS, (trig << 5) | 32'h14);
        waitDone();
        waitCyc(30);
        axRead(`ASCS_CTRL_OFS, rd);
        chk("stop on first", (trig << 5) | 32'h11, rd);
        chk("single sequence", 32'(c0 + 1), 32'(nConv));
        $display("test auto stop done");
        c0 = nConv;
        axWrite(`ASCS_CTRL_OFS, (trig << 5) | 32'h04);
        waitCyc(70);
        chk("auto restarts", 32'h1, {31'h0, (nConv - c0) >= 2});
        axWrite(`ASCS_CTRL_OFS, trig << 5);
        waitCyc(40);
        axRead(`ASCS_RESULT_OFS, rd);
        chk("result overwritten", {22'h0, lastWord}, rd);
        c0 = nConv;
        waitCyc(40);
        chk("no self start", 32'(c0), 32'(nConv));
        chk("holding", 32'h0, {31'h0, sampleHold});
        $display("test auto run done");
        axWrite(`ASCS_IRQ_MASK_OFS, 32'h0);
        waitCyc(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        axWrite(`ASCS_IRQ_MASK_OFS, 32'h1);
        waitCyc(2);
        chk("irq raised", 32'h1, {31'h0, irq});
        axWrite(`ASCS_IRQ_STAT_OFS, 32'h3);
        waitCyc(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        axRead(`ASCS_IRQ_STAT_OFS, rd);
        chk("status cleared", 32'h0, rd);
        $display("test interrupt done");
        testDone();
    end
endmodule // adc_sample_convert_sequencer_tb
`default_nettype wire
